// ==== dv/xmr_ext_sram.sv ====
// Model: off-chip byte memory with address latch behind the router pins
`timescale 1ns/1ps
`default_nettype none
module xmr_ext_sram
#(
   parameter logic [7:0] PARK_HIGH = 8'hFF
)
(
   input  wire logic                  clk,
   input  wire xmr_pkg::xmr_pins_type low_pins,
   input  wire xmr_pkg::xmr_pins_type high_pins,
   input  wire logic                  low_claim,
   input  wire logic                  high_claim,
   output var  logic [7:0]            data_in
);
   xmr_pkg::xmr_pins_type p;
   logic [7:0]  mem [0:65535];
   logic [7:0]  lat;
   logic [7:0]  last_q = 8'h00;
   logic        mux_seen = 1'b0;
   logic        rd_seen = 1'b0;
   logic [15:0] a;
   assign p = high_claim ? high_pins : low_pins;
   // Transparent while latch enable is high
   always_latch
      if (p.ale)
         lat <= (p.addr_oe != 8'h00) ? p.addr[7:0] : p.data;
   // Undriven upper lines show the parked port latch level
   assign a = {(p.addr_hi_oe != 8'h00) ? p.addr[15:8] : PARK_HIGH,
      mux_seen ? lat : p.addr[7:0]};
   always @(posedge clk)
   begin
      mux_seen <= (low_claim || high_claim) && (mux_seen || p.ale);
      rd_seen <= (low_claim || high_claim) && (rd_seen || !p.rd_n);
      if (!p.wr_n && p.ctl_oe)
         mem[a] <= p.data;
      last_q <= data_in;
   end
   // Idle bus toggles so a stale value is never mistaken for data
   assign data_in = (rd_seen || !p.rd_n) ? mem[a] : ~last_q;
endmodule // xmr_ext_sram
`default_nettype wire

// ==== dv/xmr_router_monitor.sv ====
// Checker: pin ownership, strobe and handshake relations of the router
`timescale 1ns/1ps
`default_nettype none
module xmr_router_monitor
(
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire xmr_pkg::xmr_pins_type low_pins,
   input wire xmr_pkg::xmr_pins_type high_pins,
   input wire logic                  low_claim,
   input wire logic                  high_claim
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   logic strb;
   logic any_claim;
   assign strb = !low_pins.rd_n || !low_pins.wr_n
      || !high_pins.rd_n || !high_pins.wr_n;
   assign any_claim = low_claim || high_claim;
   ////////////////////////////////////////////////////////////////////////
   park_low_a: assert property (
      !low_claim |-> low_pins.rd_n && low_pins.wr_n && !low_pins.ctl_oe
      && low_pins.addr_oe == 8'h00 && low_pins.data_oe == 8'h00
      && low_pins.addr_hi_oe == 8'h00 && !low_pins.ale)
      else $error("low group active while not claimed");
   park_high_a: assert property (
      !high_claim |-> high_pins.rd_n && high_pins.wr_n && !high_pins.ctl_oe
      && high_pins.addr_hi_oe == 8'h00 && high_pins.data_oe == 8'h00
      && high_pins.addr_oe == 8'h00 && !high_pins.ale)
      else $error("high group active while not claimed");
   one_group_a: assert property (!(low_claim && high_claim))
      else $error("both pin groups claimed");
   read_float_a: assert property (
      !low_pins.rd_n || !high_pins.rd_n |->
      low_pins.data_oe == 8'h00 && high_pins.data_oe == 8'h00)
      else $error("data drivers on during read strobe");
   write_drive_a: assert property (
      !low_pins.wr_n |-> low_pins.data_oe == 8'hFF)
      else $error("data not driven during write strobe");
   strobe_one_a: assert property (strb |=> !strb)
      else $error("strobe longer than one cycle");
   latch_apart_a: assert property (
      low_pins.ale || high_pins.ale |-> !strb ##1 !strb)
      else $error("strobe too close to address latch");
   claim_len_a: assert property (
      $rose(any_claim) |-> any_claim [*5] ##[1:9] !any_claim)
      else $error("off-chip access length out of range");
   mux_share_a: assert property (
      low_pins.ale || high_pins.ale |-> low_pins.addr_oe == 8'h00
      && high_pins.addr_oe == 8'h00
      && (low_pins.data_oe | high_pins.data_oe) == 8'hFF)
      else $error("latch phase not on shared pins");
   bhold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped");
endmodule // xmr_router_monitor
bind xmr_router xmr_router_monitor i_mon (.clk, .resetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .low_pins, .high_pins,
   .low_claim, .high_claim);
`default_nettype wire

// ==== dv/xmr_router_tb_top.sv ====
// Testbench: register accesses and off-chip transfers of the router
`timescale 1ns/1ps
`default_nettype none
module xmr_router_tb_top;
   logic clk = 1'b0, resetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, low_claim, high_claim;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] data_in;
   xmr_pkg::xmr_pins_type low_pins, high_pins;
   int err_total = 0, n_compared = 0;
   int lo_cnt = 0, hi_cnt = 0, ale_run = 0, ale_last = 0, ale_tot = 0;
   int l0, h0, a0;
   logic [31:0] d;
   logic [1:0] r;
   xmr_router i_dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_in, .low_pins,
      .high_pins, .low_claim, .high_claim);
   xmr_ext_sram i_mem (.clk, .low_pins, .high_pins, .low_claim,
      .high_claim, .data_in);
   always #2.5 clk = ~clk;
   // Pin activity counters
   always @(posedge clk)
   begin
      if (low_claim === 1'b1) lo_cnt++;
      if (high_claim === 1'b1) hi_cnt++;
      if ((low_pins.ale & low_pins.ctl_oe | high_pins.ale & high_pins.ctl_oe)
         === 1'b1) ale_run++;
      else if (ale_run != 0)
      begin
         ale_last = ale_run;
         ale_run = 0;
         ale_tot++;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ba(input logic [7:0] i);
      return {22'h0, i, 2'h0};
   endfunction
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", what, e, g);
      end
   endtask
   task automatic chk_cnt(input string what, input int e, input int g);
      n_compared++;
      if (g != e)
      begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] i, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= ba(i);
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 300);
      s_axi_bready <= 1'b0;
      chk_cnt("write done", 1, int'(s_axi_bvalid === 1'b1));
      chk("write response", 32'h0, {30'h0, s_axi_bresp});
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] v,
      output logic [1:0] rr);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 300);
      v = s_axi_rdata;
      rr = s_axi_rresp;
      chk_cnt("read done", 1, int'(s_axi_rvalid === 1'b1));
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] i,
      input logic [31:0] e);
      axi_rd(ba(i), d, r);
      chk(what, e, d);
   endtask
   // Loads config and operands, starts one access, waits for idle
   task automatic access(input logic [7:0] cfg, pg, ix, input logic [15:0] p,
      input logic [7:0] v, input logic [1:0] cmd);
      int k;
      k = 0;
      axi_wr(xmr_pkg::ADDR_MEM_CONFIG, cfg);
      axi_wr(xmr_pkg::ADDR_PAGE_SELECT, pg);
      axi_wr(xmr_pkg::ADDR_INDEX, ix);
      axi_wr(xmr_pkg::ADDR_PTR_LOW, p[7:0]);
      axi_wr(xmr_pkg::ADDR_PTR_HIGH, p[15:8]);
      axi_wr(xmr_pkg::ADDR_PROC_DATA, v);
      l0 = lo_cnt;
      h0 = hi_cnt;
      a0 = ale_tot;
      axi_wr(xmr_pkg::ADDR_PROC_CMD, {6'h0, cmd});
      do
      begin
         axi_rd(ba(xmr_pkg::ADDR_PROC_STATUS), d, r);
         k++;
      end
      while (d[0] !== 1'b0 && k < 50);
      chk("busy", 32'h0, {31'h0, d[0]});
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      err_total++;
      $display("ERROR run expected done seen timeout");
      wrap_up();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rchk("page reset", xmr_pkg::ADDR_PAGE_SELECT, 32'h00);
      rchk("config reset", xmr_pkg::ADDR_MEM_CONFIG, 32'h03);
      axi_wr(xmr_pkg::ADDR_MEM_CONFIG, 8'hFF);
      rchk("config top bits", xmr_pkg::ADDR_MEM_CONFIG, 32'h3F);
      axi_rd(32'h400, d, r);
      chk("unmapped resp", 32'h2, {30'h0, r});
      // On-chip only: 0x2005 aliases to 0x0005
      access(8'h10, 8'h00, 8'h00, 16'h2005, 8'hA5, 2'h3);
      access(8'h10, 8'h00, 8'h00, 16'h0005, 8'h00, 2'h2);
      rchk("wrap read", xmr_pkg::ADDR_PROC_DATA, 32'hA5);
      chk_cnt("on-chip claims", l0 + h0, lo_cnt + hi_cnt);
      // Off-chip only, separate pins, low group, shortest latch setting
      access(8'h1C, 8'h00, 8'h00, 16'h1234, 8'h5A, 2'h3);
      chk("mem 1234", 32'h5A, 32'(i_mem.mem[16'h1234]));
      chk_cnt("high idle", h0, hi_cnt);
      chk_cnt("low used", 1, int'(lo_cnt > l0));
      chk_cnt("no latch", a0, ale_tot);
      i_mem.mem[16'h0042] = 8'hC3;
      access(8'h1C, 8'h00, 8'h00, 16'h0042, 8'h00, 2'h2);
      rchk("off-chip read", xmr_pkg::ADDR_PROC_DATA, 32'hC3);
      // Bank select, multiplexed, high group, widest latch pulse
      access(8'h2B, 8'h40, 8'h77, 16'h0000, 8'h3C, 2'h1);
      chk("mem 4077", 32'h3C, 32'(i_mem.mem[16'h4077]));
      chk_cnt("latch width 4", 4, ale_last);
      chk_cnt("low idle", l0, lo_cnt);
      // Page above on-chip range so index accesses go off-chip
      access(8'h04, 8'h40, 8'h78, 16'h0000, 8'h6D, 2'h1);
      chk("mem FF78", 32'h6D, 32'(i_mem.mem[16'hFF78]));
      access(8'h04, 8'h10, 8'h11, 16'h0000, 8'h99, 2'h1);
      chk_cnt("split on-chip", l0 + h0, lo_cnt + hi_cnt);
      access(8'h04, 8'h10, 8'h11, 16'h0000, 8'h00, 2'h0);
      rchk("split read", xmr_pkg::ADDR_PROC_DATA, 32'h99);
      for (int w = 0; w < 3; w++)
      begin
         access(8'h28 | 8'(w), 8'h00, 8'h00, 16'h9000 | 16'(w), 8'(w), 2'h3);
         chk_cnt("latch width", w + 1, ale_last);
         chk("mem 900x", 32'(w), 32'(i_mem.mem[16'h9000 | 16'(w)]));
      end
      wrap_up();
   end
endmodule // xmr_router_tb_top
`default_nettype wire

// ==== verilog/xmr_pkg.sv ====
// Package: register map, fields and types of the external data memory router
package xmr_pkg;

   localparam logic [7:0] ADDR_PAGE_SELECT = 8'hA2;
   localparam logic [7:0] ADDR_MEM_CONFIG  = 8'hA3;
   localparam logic [7:0] ADDR_PROC_CMD    = 8'hA4;
   localparam logic [7:0] ADDR_PROC_DATA   = 8'hA5;
   localparam logic [7:0] ADDR_PROC_STATUS = 8'hA6;
   localparam logic [7:0] ADDR_PTR_LOW     = 8'hA7;
   localparam logic [7:0] ADDR_PTR_HIGH    = 8'hA8;
   localparam logic [7:0] ADDR_INDEX       = 8'hA9;

   localparam logic [7:0] RESET_PAGE_SELECT = 8'h00;
   localparam logic [7:0] RESET_MEM_CONFIG  = 8'h03;
   localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3F;

   localparam int POS_PORT_GROUP  = 5;
   localparam int POS_MULTIPLEX   = 4;
   localparam int POS_MODE        = 2;
   localparam int POS_LATCH_WIDTH = 0;

   localparam logic [1:0] MODE_INTERNAL   = 2'h0;
   localparam logic [1:0] MODE_SPLIT_NOBS = 2'h1;
   localparam logic [1:0] MODE_SPLIT_BS   = 2'h2;
   localparam logic [1:0] MODE_EXTERNAL   = 2'h3;

   localparam int ONCHIP_ADDR_BITS = 13;
   localparam int BASE_ACCESS_CYCLES = 4;
   localparam int STROBE_CYCLES   = 1;

   typedef enum logic [1:0] {
      XMR_RESP_OKAY   = 2'h0,
      XMR_RESP_SLVERR = 2'h2
   } xmr_resp_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  addr_oe;
      logic [7:0]  addr_hi_oe;
      logic [7:0]  data;
      logic [7:0]  data_oe;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic        ctl_oe;
   } xmr_pins_type;

endpackage

// ==== verilog/xmr_router.sv ====
// External data memory router: registers, address resolution, pin sequencer
`timescale 1ns/1ps
`default_nettype none

module xmr_router
#(
   parameter int RAM_BYTES = 8192
)
(
   input  wire  logic                 clk,
   input  wire  logic                 resetn,
   input  wire  logic [31:0]          s_axi_awaddr,
   input  wire  logic                 s_axi_awvalid,
   output var   logic                 s_axi_awready,
   input  wire  logic [31:0]          s_axi_wdata,
   input  wire  logic [3:0]           s_axi_wstrb,
   input  wire  logic                 s_axi_wvalid,
   output var   logic                 s_axi_wready,
   output var   logic [1:0]           s_axi_bresp,
   output var   logic                 s_axi_bvalid,
   input  wire  logic                 s_axi_bready,
   input  wire  logic [31:0]          s_axi_araddr,
   input  wire  logic                 s_axi_arvalid,
   output var   logic                 s_axi_arready,
   output var   logic [31:0]          s_axi_rdata,
   output var   logic [1:0]           s_axi_rresp,
   output var   logic                 s_axi_rvalid,
   input  wire  logic                 s_axi_rready,
   input  wire  logic [7:0]           data_in,
   output var   xmr_pkg::xmr_pins_type low_pins,
   output var   xmr_pkg::xmr_pins_type high_pins,
   output var   logic                 low_claim,
   output var   logic                 high_claim
);

   ////////////////////////////////////////////////////////////////////////
   // Types and helpers

   typedef enum logic [2:0] {
      XMR_IDLE,
      XMR_ALE_HIGH,
      XMR_ALE_LOW,
      XMR_STROBE,
      XMR_TAIL
   } xmr_state_type;

   function automatic logic is_onchip(input logic [1:0] mode,
                                      input logic [15:0] ea);
      logic hi;
      hi = |ea[15:xmr_pkg::ONCHIP_ADDR_BITS];
      case (mode)
         xmr_pkg::MODE_INTERNAL: is_onchip = 1'b1;
         xmr_pkg::MODE_EXTERNAL: is_onchip = 1'b0;
         default:                is_onchip = !hi;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0]  page_r, page_nxt;
   logic [5:0]  cfg_r, cfg_nxt;
   logic [15:0] ptr_r, ptr_nxt;
   logic [7:0]  index_r, index_nxt;
   logic [7:0]  wdat_r, wdat_nxt;
   logic [7:0]  rdat_r, rdat_nxt;
   logic        busy_r, busy_nxt;
   logic        is_wr_r, is_wr_nxt;
   logic        use_ptr_r, use_ptr_nxt;
   logic        drive_hi_r, drive_hi_nxt;
   logic        mux_r, mux_nxt;
   logic        grp_r, grp_nxt;
   logic [15:0] ea_r, ea_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic [7:0]  din_s1_r, din_s1_nxt;
   logic [7:0]  din_s2_r, din_s2_nxt;
   logic [7:0]  din_s3_r, din_s3_nxt;
   xmr_state_type st_r, st_nxt;
   logic [7:0]  ram [RAM_BYTES];

   logic        aw_r, aw_nxt;
   logic [7:0]  awa_r, awa_nxt;
   logic        w_r, w_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic        bv_r, bv_nxt;
   logic [1:0]  br_r, br_nxt;
   logic        rv_r, rv_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic [1:0]  rr_r, rr_nxt;
   xmr_pkg::xmr_pins_type pins_r, pins_nxt;
   logic        claim_r, claim_nxt;

   logic        ram_we;
   logic [12:0] ram_a;
   logic [15:0] ea_c;
   logic        start;
   logic        do_wr;

   ////////////////////////////////////////////////////////////////////////
   // Register bus and access launch

   always_comb
   begin
      aw_nxt = aw_r;
      awa_nxt = awa_r;
      w_nxt = w_r;
      wd_nxt = wd_r;
      bv_nxt = bv_r;
      br_nxt = br_r;
      rv_nxt = rv_r;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      page_nxt = page_r;
      cfg_nxt = cfg_r;
      ptr_nxt = ptr_r;
      index_nxt = index_r;
      wdat_nxt = wdat_r;
      start = 1'b0;
      do_wr = 1'b0;
      if (s_axi_awvalid && !aw_r)
      begin
         aw_nxt = 1'b1;
         awa_nxt = s_axi_awaddr[9:2] == 8'h00 ? 8'h00 : s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_r)
      begin
         w_nxt = 1'b1;
         wd_nxt = {s_axi_wdata[31:8], s_axi_wstrb[0] ? s_axi_wdata[7:0]
                   : 8'h00};
      end
      if (aw_r && w_r && !bv_r && !busy_r)
      begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = xmr_pkg::XMR_RESP_OKAY;
         if (awa_r == xmr_pkg::ADDR_PAGE_SELECT)
            page_nxt = wd_r[7:0];
         else if (awa_r == xmr_pkg::ADDR_MEM_CONFIG)
            cfg_nxt = wd_r[5:0] & xmr_pkg::CONFIG_WRITE_MASK[5:0];
         else if (awa_r == xmr_pkg::ADDR_PTR_LOW)
            ptr_nxt[7:0] = wd_r[7:0];
         else if (awa_r == xmr_pkg::ADDR_PTR_HIGH)
            ptr_nxt[15:8] = wd_r[7:0];
         else if (awa_r == xmr_pkg::ADDR_INDEX)
            index_nxt = wd_r[7:0];
         else if (awa_r == xmr_pkg::ADDR_PROC_DATA)
            wdat_nxt = wd_r[7:0];
         else if (awa_r == xmr_pkg::ADDR_PROC_CMD)
         begin
            start = 1'b1;
            do_wr = wd_r[0];
         end
         else
            br_nxt = xmr_pkg::XMR_RESP_SLVERR;
      end
      if (bv_r && s_axi_bready)
         bv_nxt = 1'b0;
      if (s_axi_arvalid && !rv_r)
      begin
         rv_nxt = 1'b1;
         rr_nxt = xmr_pkg::XMR_RESP_OKAY;
         rd_nxt = 32'h0000_0000;
         if (s_axi_araddr[9:2] == xmr_pkg::ADDR_PAGE_SELECT)
            rd_nxt[7:0] = page_r;
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_MEM_CONFIG)
            rd_nxt[7:0] = {2'b00, cfg_r};
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_PTR_LOW)
            rd_nxt[7:0] = ptr_r[7:0];
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_PTR_HIGH)
            rd_nxt[7:0] = ptr_r[15:8];
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_INDEX)
            rd_nxt[7:0] = index_r;
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_PROC_DATA)
            rd_nxt[7:0] = rdat_r;
         else if (s_axi_araddr[9:2] == xmr_pkg::ADDR_PROC_STATUS)
            rd_nxt[7:0] = {7'h00, busy_r};
         else if (s_axi_araddr[9:2] != xmr_pkg::ADDR_PROC_CMD)
            rr_nxt = xmr_pkg::XMR_RESP_SLVERR;
      end
      else if (rv_r && s_axi_rready)
         rv_nxt = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      is_wr_nxt = is_wr_r;
      use_ptr_nxt = use_ptr_r;
      drive_hi_nxt = drive_hi_r;
      mux_nxt = mux_r;
      grp_nxt = grp_r;
      ea_nxt = ea_r;
      rdat_nxt = rdat_r;
      claim_nxt = claim_r;
      pins_nxt = pins_r;
      // Read data pins are asynchronous to the clock
      din_s1_nxt = data_in;
      din_s2_nxt = din_s1_r;
      din_s3_nxt = din_s2_r;
      ram_we = 1'b0;
      ram_a = ea_r[12:0];
      ea_c = wd_r[1] ? ptr_r : {page_r, index_r};
      case (st_r)
         XMR_IDLE:
         begin
            claim_nxt = 1'b0;
            pins_nxt = '0;
            pins_nxt.rd_n = 1'b1;
            pins_nxt.wr_n = 1'b1;
            pins_nxt.ale = 1'b0;
            if (start)
            begin
               is_wr_nxt = do_wr;
               use_ptr_nxt = wd_r[1];
               ea_nxt = ea_c;
               if (is_onchip(cfg_r[3:2], ea_c))
               begin
                  ram_a = ea_c[12:0];
                  ram_we = do_wr;
                  rdat_nxt = ram[ram_a];
               end
               else
               begin
                  busy_nxt = 1'b1;
                  mux_nxt = !cfg_r[xmr_pkg::POS_MULTIPLEX];
                  grp_nxt = cfg_r[xmr_pkg::POS_PORT_GROUP];
                  // Index access drives page only with bank select
                  drive_hi_nxt = wd_r[1] ||
                     cfg_r[3:2] == xmr_pkg::MODE_SPLIT_BS;
                  claim_nxt = 1'b1;
                  pins_nxt.ctl_oe = 1'b1;
                  pins_nxt.addr = ea_c;
                  // Low address lines idle when AD pins carry it
                  pins_nxt.addr_oe = cfg_r[xmr_pkg::POS_MULTIPLEX]
                     ? 8'hFF : 8'h00;
                  pins_nxt.addr_hi_oe = (wd_r[1] ||
                     cfg_r[3:2] == xmr_pkg::MODE_SPLIT_BS) ? 8'hFF : 8'h00;
                  cnt_nxt = 3'(cfg_r[1:0]);
                  if (!cfg_r[xmr_pkg::POS_MULTIPLEX])
                  begin
                     // Shared pins carry the low address byte first
                     pins_nxt.ale = 1'b1;
                     pins_nxt.data = ea_c[7:0];
                     pins_nxt.data_oe = 8'hFF;
                     st_nxt = XMR_ALE_HIGH;
                  end
                  else
                  begin
                     pins_nxt.data = wdat_r;
                     pins_nxt.data_oe = do_wr ? 8'hFF : 8'h00;
                     cnt_nxt = 3'(xmr_pkg::STROBE_CYCLES - 1);
                     pins_nxt.rd_n = do_wr;
                     pins_nxt.wr_n = !do_wr;
                     st_nxt = XMR_STROBE;
                  end
               end
            end
         end
         XMR_ALE_HIGH:
            if (cnt_r == 3'h0)
            begin
               pins_nxt.ale = 1'b0;
               pins_nxt.data_oe = 8'h00;
               cnt_nxt = 3'(cfg_r[1:0]);
               st_nxt = XMR_ALE_LOW;
            end
            else
               cnt_nxt = cnt_r - 3'h1;
         XMR_ALE_LOW:
            if (cnt_r == 3'h0)
            begin
               pins_nxt.data = wdat_r;
               pins_nxt.data_oe = is_wr_r ? 8'hFF : 8'h00;
               pins_nxt.rd_n = is_wr_r;
               pins_nxt.wr_n = !is_wr_r;
               cnt_nxt = 3'(xmr_pkg::STROBE_CYCLES - 1);
               st_nxt = XMR_STROBE;
            end
            else
               cnt_nxt = cnt_r - 3'h1;
         XMR_STROBE:
            if (cnt_r == 3'h0)
            begin
               pins_nxt.rd_n = 1'b1;
               pins_nxt.wr_n = 1'b1;
               cnt_nxt = 3'(xmr_pkg::BASE_ACCESS_CYCLES - 1);
               st_nxt = XMR_TAIL;
            end
            else
               cnt_nxt = cnt_r - 3'h1;
         XMR_TAIL:
            if (cnt_r == 3'h0)
            begin
               // Pins lag one cycle; synchroniser adds three more
               if (!is_wr_r && din_s2_r == din_s3_r)
                  rdat_nxt = din_s3_r;
               busy_nxt = 1'b0;
               claim_nxt = 1'b0;
               pins_nxt = '0;
               pins_nxt.rd_n = 1'b1;
               pins_nxt.wr_n = 1'b1;
               st_nxt = XMR_IDLE;
            end
            else
               cnt_nxt = cnt_r - 3'h1;
         default:
            st_nxt = XMR_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk)
   begin
      if (ram_we)
         ram[ram_a] <= wdat_r;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_r <= 1'b0;
         awa_r <= 8'h00;
         w_r <= 1'b0;
         wd_r <= 32'h0000_0000;
         bv_r <= 1'b0;
         br_r <= 2'h0;
         rv_r <= 1'b0;
         rd_r <= 32'h0000_0000;
         rr_r <= 2'h0;
         page_r <= xmr_pkg::RESET_PAGE_SELECT;
         cfg_r <= xmr_pkg::RESET_MEM_CONFIG[5:0];
         ptr_r <= 16'h0000;
         index_r <= 8'h00;
         wdat_r <= 8'h00;
         rdat_r <= 8'h00;
         busy_r <= 1'b0;
         is_wr_r <= 1'b0;
         use_ptr_r <= 1'b0;
         drive_hi_r <= 1'b0;
         mux_r <= 1'b0;
         grp_r <= 1'b0;
         ea_r <= 16'h0000;
         cnt_r <= 3'h0;
         din_s1_r <= 8'h00;
         din_s2_r <= 8'h00;
         din_s3_r <= 8'h00;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_arready <= 1'b1;
         st_r <= XMR_IDLE;
         claim_r <= 1'b0;
         pins_r <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
      end
      else
      begin
         aw_r <= aw_nxt;
         awa_r <= awa_nxt;
         w_r <= w_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rr_r <= rr_nxt;
         page_r <= page_nxt;
         cfg_r <= cfg_nxt;
         ptr_r <= ptr_nxt;
         index_r <= index_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         busy_r <= busy_nxt;
         is_wr_r <= is_wr_nxt;
         use_ptr_r <= use_ptr_nxt;
         drive_hi_r <= drive_hi_nxt;
         mux_r <= mux_nxt;
         grp_r <= grp_nxt;
         ea_r <= ea_nxt;
         cnt_r <= cnt_nxt;
         din_s1_r <= din_s1_nxt;
         din_s2_r <= din_s2_nxt;
         din_s3_r <= din_s3_nxt;
         s_axi_awready <= !aw_nxt;
         s_axi_wready <= !w_nxt;
         s_axi_arready <= !rv_nxt;
         st_r <= st_nxt;
         claim_r <= claim_nxt;
         pins_r <= pins_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin group steering; output mode stays with the port logic

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         low_pins <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
         high_pins <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
         low_claim <= 1'b0;
         high_claim <= 1'b0;
      end
      else
      begin
         low_pins <= grp_r ? '{rd_n: 1'b1, wr_n: 1'b1, default: '0}
                     : pins_r;
         high_pins <= grp_r ? pins_r
                      : '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
         low_claim <= claim_r && !grp_r;
         high_claim <= claim_r && grp_r;
      end
   end

   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = br_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rdata = rd_r;
   assign s_axi_rresp = rr_r;

endmodule // xmr_router

`default_nettype wire
